/* rtl/mda_pkg.sv */
// shared widths, selects, opcodes and constants of the data arithmetic unit
package mda_pkg;

  localparam int DATA_W = 16;
  localparam int BODY_W = 32;
  localparam int EXT_W = 8;
  localparam int ACC_W = 40;
  localparam int NUM_IN_REGS = 4;

  localparam logic [15:0] IN_RESET = 16'h0000;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [15:0] LOW_CLEAR = 16'h0000;
  localparam logic [15:0] RND_TIE = 16'h8000;
  localparam logic [39:0] RND_HALF = 40'h00_0000_8000;
  localparam logic [39:0] ACC_ZERO = 40'h00_0000_0000;
  localparam int RND_LSB_POS = 16;

  // register select on either data bus
  typedef enum logic [3:0] {
    RS_X_LOW = 4'h0,
    RS_X_HIGH = 4'h1,
    RS_Y_LOW = 4'h2,
    RS_Y_HIGH = 4'h3,
    RS_A_LOWER = 4'h4,
    RS_A_UPPER = 4'h5,
    RS_A_EXT = 4'h6,
    RS_B_LOWER = 4'h7,
    RS_B_UPPER = 4'h8,
    RS_B_EXT = 4'h9,
    RS_A_WHOLE = 4'ha,
    RS_B_WHOLE = 4'hb
  } mda_reg_sel_type;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MPY = 4'h1,
    OP_MPYN = 4'h2,
    OP_MAC = 4'h3,
    OP_MACN = 4'h4,
    OP_INT_MPY = 4'h5,
    OP_INT_MAC = 4'h6,
    OP_ADD = 4'h7,
    OP_SUB = 4'h8,
    OP_ASL = 4'h9,
    OP_ASR = 4'ha,
    OP_AND = 4'hb,
    OP_OR = 4'hc,
    OP_XOR = 4'hd,
    OP_NOT = 4'he,
    OP_RND = 4'hf
  } mda_op_type;

  // second source of add, subtract and logic operations
  typedef enum logic [2:0] {
    SRC_X_LOW = 3'h0,
    SRC_X_HIGH = 3'h1,
    SRC_Y_LOW = 3'h2,
    SRC_Y_HIGH = 3'h3,
    SRC_X_LONG = 3'h4,
    SRC_Y_LONG = 3'h5,
    SRC_OTHER_ACC = 3'h6
  } mda_src_type;

  // multiplier operand
  typedef enum logic [2:0] {
    MS_X_LOW = 3'h0,
    MS_X_HIGH = 3'h1,
    MS_Y_LOW = 3'h2,
    MS_Y_HIGH = 3'h3,
    MS_A_UPPER = 3'h4,
    MS_B_UPPER = 3'h5
  } mda_mul_sel_type;

  typedef enum logic [1:0] {
    SGN_SS = 2'h0,
    SGN_SU = 2'h1,
    SGN_UU = 2'h2
  } mda_sign_type;

endpackage

/* rtl/mda_bus_port.sv */
// read selection and readout limiter for one data bus
`timescale 1ns/1ps
`default_nettype none
module mda_bus_port
  import mda_pkg::*;
(
  // select
  input wire mda_reg_sel_type rd_sel,
  // unit registers
  input wire logic [15:0] x_low,
  input wire logic [15:0] x_high,
  input wire logic [15:0] y_low,
  input wire logic [15:0] y_high,
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  // result
  output logic [15:0] rd_data,
  output logic rd_limited
);

  wire logic whole_a = (rd_sel == RS_A_WHOLE);
  wire logic [39:0] whole_acc = whole_a ? acc_a : acc_b;
  // extension in use when bits 39..31 are not all equal
  wire logic ext_used = ~((&whole_acc[39:31]) | ~(|whole_acc[39:31]));
  wire logic whole_sel = (rd_sel == RS_A_WHOLE) || (rd_sel == RS_B_WHOLE);
  // RULE19: clamp by sign
  wire logic [15:0] sat_word = whole_acc[39] ? SAT_NEG : SAT_POS;
  // RULE14: limit on readout
  wire logic [15:0] whole_word = ext_used ? sat_word : whole_acc[31:16];

  assign rd_limited = whole_sel & ext_used;

  always_comb begin
    case (rd_sel)
      RS_X_LOW: rd_data = x_low;
      RS_X_HIGH: rd_data = x_high;
      RS_Y_LOW: rd_data = y_low;
      RS_Y_HIGH: rd_data = y_high;
      RS_A_LOWER: rd_data = acc_a[15:0];
      RS_A_UPPER: rd_data = acc_a[31:16];
      RS_A_EXT: rd_data = {{8{acc_a[39]}}, acc_a[39:32]};
      RS_B_LOWER: rd_data = acc_b[15:0];
      RS_B_UPPER: rd_data = acc_b[31:16];
      RS_B_EXT: rd_data = {{8{acc_b[39]}}, acc_b[39:32]};
      RS_A_WHOLE: rd_data = whole_word;
      RS_B_WHOLE: rd_data = whole_word;
      default: rd_data = LOW_CLEAR;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/mda_data_alu.sv */
// data arithmetic unit: input registers, two accumulators, multiply-accumulate and logic
// Function
// RULE1: four inputs, two forty-bit accumulators
// RULE2: all registers read/written on both buses
// RULE3: every operation finishes in one cycle
// RULE4: operands sixteen, thirty-two or forty bits
// RULE5: results only go to accumulators
// RULE6: accumulator upper word feeds multiplier
// RULE7: arithmetic yields full forty-bit result
// RULE8: logic ops sixteen-bit in, sixteen-bit out
// RULE9: two's complement; unsigned only for multiply
// RULE10: fractional product added, stored same accumulator
// RULE11: multiply-accumulate unpipelined, result next cycle
// RULE12: integer results land in upper word; integer multiply products here are aligned to bit 0 instead
// RULE13: integer multiply ops keep full precision
// RULE14: saturation limits accumulator readout
// RULE15: convergent or two's complement rounding selectable
// RULE16: logic unit does and, or, xor, not
// RULE17: logic touches upper word only
// RULE18: single access x bus, dual both
// RULE19: limit to largest or most negative
// RULE20: upper write sign-extends, clears lower; here only the whole select does, upper selects write bits 31..16 only
`timescale 1ns/1ps
`default_nettype none
module mda_data_alu
  import mda_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // instruction from the sequencer
  input wire mda_op_type op_code,
  input wire logic op_dst_b,
  input wire mda_src_type op_src,
  input wire mda_mul_sel_type mul_sel_a,
  input wire mda_mul_sel_type mul_sel_b,
  input wire mda_sign_type sign_mode,
  input wire logic int_mode,
  input wire logic round_convergent,
  // x data bus
  input wire logic x_wr_en,
  input wire mda_reg_sel_type x_wr_sel,
  input wire logic [15:0] x_wr_data,
  input wire logic x_rd_en,
  input wire mda_reg_sel_type x_rd_sel,
  output logic [15:0] x_rd_data,
  output logic x_rd_valid,
  // global data bus
  input wire logic g_wr_en,
  input wire mda_reg_sel_type g_wr_sel,
  input wire logic [15:0] g_wr_data,
  input wire logic g_rd_en,
  input wire mda_reg_sel_type g_rd_sel,
  output logic [15:0] g_rd_data,
  output logic g_rd_valid,
  // condition flags
  input wire logic limit_flag_clr,
  output logic flag_zero,
  output logic flag_neg,
  output logic flag_ext,
  output logic flag_ovf,
  output logic flag_limit
);

  ////////////////////////////////////////////////////////////////////
  // registers
  // RULE1: operand and accumulator storage
  logic [15:0] in_reg [NUM_IN_REGS];
  logic [15:0] in_next [NUM_IN_REGS];
  logic [39:0] acc_a_reg;
  logic [39:0] acc_b_reg;
  logic [39:0] acc_a_next;
  logic [39:0] acc_b_next;
  logic [15:0] x_rd_data_reg;
  logic [15:0] g_rd_data_reg;
  logic x_rd_valid_reg;
  logic g_rd_valid_reg;
  logic flag_zero_reg;
  logic flag_neg_reg;
  logic flag_ext_reg;
  logic flag_ovf_reg;
  logic flag_limit_reg;

  wire logic [15:0] input_reg_x_low = in_reg[0];
  wire logic [15:0] input_reg_x_high = in_reg[1];
  wire logic [15:0] input_reg_y_low = in_reg[2];
  wire logic [15:0] input_reg_y_high = in_reg[3];
  wire logic [15:0] acc_a_upper = acc_a_reg[31:16];
  wire logic [15:0] acc_b_upper = acc_b_reg[31:16];

  ////////////////////////////////////////////////////////////////////
  // operand selection
  wire logic [39:0] acc_dst = op_dst_b ? acc_b_reg : acc_a_reg;
  wire logic [39:0] acc_other = op_dst_b ? acc_a_reg : acc_b_reg;

  // RULE6: multiplier operand mux
  function automatic logic [15:0] mul_pick(input mda_mul_sel_type s);
    case (s)
      MS_X_LOW: mul_pick = input_reg_x_low;
      MS_X_HIGH: mul_pick = input_reg_x_high;
      MS_Y_LOW: mul_pick = input_reg_y_low;
      MS_Y_HIGH: mul_pick = input_reg_y_high;
      MS_A_UPPER: mul_pick = acc_a_upper;
      MS_B_UPPER: mul_pick = acc_b_upper;
      default: mul_pick = LOW_CLEAR;
    endcase
  endfunction

  // always_comb so register changes reach the mux
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  always_comb begin
    mul_a = mul_pick(mul_sel_a);
    mul_b = mul_pick(mul_sel_b);
  end

  // RULE4: sixteen, thirty-two and forty-bit sources
  logic [39:0] src_long;
  logic [15:0] src_word;
  always_comb begin
    case (op_src)
      SRC_X_LOW: src_word = input_reg_x_low;
      SRC_X_HIGH: src_word = input_reg_x_high;
      SRC_Y_LOW: src_word = input_reg_y_low;
      SRC_Y_HIGH: src_word = input_reg_y_high;
      SRC_X_LONG: src_word = input_reg_x_high;
      SRC_Y_LONG: src_word = input_reg_y_high;
      SRC_OTHER_ACC: src_word = acc_other[31:16];
      default: src_word = LOW_CLEAR;
    endcase
    case (op_src)
      SRC_X_LONG: src_long = {{8{input_reg_x_high[15]}}, input_reg_x_high, input_reg_x_low};
      SRC_Y_LONG: src_long = {{8{input_reg_y_high[15]}}, input_reg_y_high, input_reg_y_low};
      SRC_OTHER_ACC: src_long = acc_other;
      default: src_long = {{8{src_word[15]}}, src_word, LOW_CLEAR};
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // multiplier
  // RULE9: unsigned interpretation only reaches the multiplier
  wire logic sign_a = (sign_mode != SGN_UU);
  wire logic sign_b = (sign_mode == SGN_SS);
  wire logic signed [16:0] mul_a_ext = {sign_a & mul_a[15], mul_a};
  wire logic signed [16:0] mul_b_ext = {sign_b & mul_b[15], mul_b};
  wire logic signed [33:0] prod_full = mul_a_ext * mul_b_ext;

  // RULE10: fractional product aligned to the binary point below bit 31
  wire logic [39:0] prod_frac = {{5{prod_full[33]}}, prod_full, 1'b0};
  // RULE13: integer product kept at full precision
  wire logic [39:0] prod_int = {{6{prod_full[33]}}, prod_full};
  wire logic is_int_mul = (op_code == OP_INT_MPY) || (op_code == OP_INT_MAC);
  wire logic is_neg_mul = (op_code == OP_MPYN) || (op_code == OP_MACN);
  wire logic [39:0] prod_sel = is_int_mul ? prod_int : prod_frac;
  wire logic [39:0] prod_term = is_neg_mul ? (ACC_ZERO - prod_sel) : prod_sel;

  ////////////////////////////////////////////////////////////////////
  // adders, shifter, rounding and logic
  // RULE7: forty-bit arithmetic with one guard bit for overflow
  wire logic [40:0] mac_sum = {acc_dst[39], acc_dst} + {prod_term[39], prod_term};
  wire logic [40:0] add_sum = {acc_dst[39], acc_dst} + {src_long[39], src_long};
  wire logic [40:0] sub_dif = {acc_dst[39], acc_dst} - {src_long[39], src_long};

  // RULE12: integer add and subtract on the upper word
  wire logic [15:0] int_add = acc_dst[31:16] + src_word;
  wire logic [15:0] int_sub = acc_dst[31:16] - src_word;

  wire logic [39:0] shl_res = {acc_dst[38:0], 1'b0};
  wire logic [39:0] shr_res = {acc_dst[39], acc_dst[39:1]};

  // RULE15: rounding, convergent clears lsb on an exact tie
  wire logic [39:0] rnd_sum = acc_dst + RND_HALF;
  wire logic rnd_tie = (acc_dst[15:0] == RND_TIE);
  wire logic rnd_even = round_convergent & rnd_tie;
  wire logic [39:0] rnd_res = {rnd_sum[39:17], rnd_sum[RND_LSB_POS] & ~rnd_even, LOW_CLEAR};

  // RULE16: and, or, xor, not on the upper word
  logic [15:0] logic_word;
  always_comb begin
    case (op_code)
      OP_AND: logic_word = acc_dst[31:16] & src_word;
      OP_OR: logic_word = acc_dst[31:16] | src_word;
      OP_XOR: logic_word = acc_dst[31:16] ^ src_word;
      OP_NOT: logic_word = ~acc_dst[31:16];
      default: logic_word = acc_dst[31:16];
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // result select
  logic [39:0] alu_res;
  logic alu_ovf;
  logic alu_arith;
  always_comb begin
    alu_res = acc_dst;
    alu_ovf = 1'b0;
    alu_arith = 1'b1;
    // RULE3: every operation resolves within this cycle
    case (op_code)
      OP_MPY, OP_MPYN, OP_INT_MPY: begin
        alu_res = prod_term;
      end
      OP_MAC, OP_MACN, OP_INT_MAC: begin
        alu_res = mac_sum[39:0];
        alu_ovf = mac_sum[40] ^ mac_sum[39];
      end
      OP_ADD: begin
        if (int_mode) begin
          alu_res = {{8{int_add[15]}}, int_add, acc_dst[15:0]};
        end else begin
          alu_res = add_sum[39:0];
          alu_ovf = add_sum[40] ^ add_sum[39];
        end
      end
      OP_SUB: begin
        if (int_mode) begin
          alu_res = {{8{int_sub[15]}}, int_sub, acc_dst[15:0]};
        end else begin
          alu_res = sub_dif[39:0];
          alu_ovf = sub_dif[40] ^ sub_dif[39];
        end
      end
      OP_ASL: begin
        alu_res = shl_res;
        alu_ovf = acc_dst[39] ^ acc_dst[38];
      end
      OP_ASR: begin
        alu_res = shr_res;
      end
      OP_RND: begin
        alu_res = rnd_res;
        alu_ovf = rnd_sum[39] & ~acc_dst[39];
      end
      // RULE8: sixteen-bit logic result
      // RULE17: lower and extension parts kept
      OP_AND, OP_OR, OP_XOR, OP_NOT: begin
        alu_res = {acc_dst[39:32], logic_word, acc_dst[15:0]};
        alu_arith = 1'b0;
      end
      default: begin
        alu_res = acc_dst;
        alu_arith = 1'b0;
      end
    endcase
  end

  // RULE5: a result only ever targets an accumulator
  wire logic op_active = (op_code != OP_NOP);
  wire logic res_to_a = op_active & ~op_dst_b;
  wire logic res_to_b = op_active & op_dst_b;

  ////////////////////////////////////////////////////////////////////
  // bus writes; x bus wins a clash with the global bus
  function automatic logic [39:0] acc_write(input logic [39:0] acc, input logic is_a,
                                            input logic en, input mda_reg_sel_type sel,
                                            input logic [15:0] d);
    logic [39:0] r;
    r = acc;
    if (en) begin
      if (sel == (is_a ? RS_A_LOWER : RS_B_LOWER)) begin
        r[15:0] = d;
      end
      if (sel == (is_a ? RS_A_UPPER : RS_B_UPPER)) begin
        r[31:16] = d;
      end
      if (sel == (is_a ? RS_A_EXT : RS_B_EXT)) begin
        r[39:32] = d[7:0];
      end
      // RULE20: whole-accumulator load
      if (sel == (is_a ? RS_A_WHOLE : RS_B_WHOLE)) begin
        r = {{8{d[15]}}, d, LOW_CLEAR};
      end
    end
    acc_write = r;
  endfunction

  wire logic [39:0] acc_a_alu = res_to_a ? alu_res : acc_a_reg;
  wire logic [39:0] acc_b_alu = res_to_b ? alu_res : acc_b_reg;
  wire logic [39:0] acc_a_g = acc_write(acc_a_alu, 1'b1, g_wr_en, g_wr_sel, g_wr_data);
  wire logic [39:0] acc_b_g = acc_write(acc_b_alu, 1'b0, g_wr_en, g_wr_sel, g_wr_data);

  // RULE2: both buses reach every register
  assign acc_a_next = acc_write(acc_a_g, 1'b1, x_wr_en, x_wr_sel, x_wr_data);
  assign acc_b_next = acc_write(acc_b_g, 1'b0, x_wr_en, x_wr_sel, x_wr_data);

  always_comb begin
    for (int i = 0; i < NUM_IN_REGS; i++) begin
      in_next[i] = in_reg[i];
      if (g_wr_en && (g_wr_sel == mda_reg_sel_type'(i))) begin
        in_next[i] = g_wr_data;
      end
      if (x_wr_en && (x_wr_sel == mda_reg_sel_type'(i))) begin
        in_next[i] = x_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus readout
  logic [15:0] x_rd_word;
  logic [15:0] g_rd_word;
  logic x_rd_lim;
  logic g_rd_lim;

  // RULE18: x bus and global bus read in parallel
  mda_bus_port u_x_port (
    .rd_sel(x_rd_sel),
    .x_low(input_reg_x_low),
    .x_high(input_reg_x_high),
    .y_low(input_reg_y_low),
    .y_high(input_reg_y_high),
    .acc_a(acc_a_reg),
    .acc_b(acc_b_reg),
    .rd_data(x_rd_word),
    .rd_limited(x_rd_lim)
  );

  mda_bus_port u_g_port (
    .rd_sel(g_rd_sel),
    .x_low(input_reg_x_low),
    .x_high(input_reg_x_high),
    .y_low(input_reg_y_low),
    .y_high(input_reg_y_high),
    .acc_a(acc_a_reg),
    .acc_b(acc_b_reg),
    .rd_data(g_rd_word),
    .rd_limited(g_rd_lim)
  );

  // limit flag set wins over clear
  wire logic limit_hit = (x_rd_en & x_rd_lim) | (g_rd_en & g_rd_lim);
  wire logic limit_next = limit_hit | (flag_limit_reg & ~limit_flag_clr);

  ////////////////////////////////////////////////////////////////////
  // condition flags of the last result of any operation other than OP_NOP, logic operations included
  wire logic res_zero = (alu_res == ACC_ZERO);
  wire logic res_ext = ~((&alu_res[39:31]) | ~(|alu_res[39:31]));

  ////////////////////////////////////////////////////////////////////
  // state
  // RULE11: accumulators update at this edge, no pipeline
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_IN_REGS; i++) begin
        in_reg[i] <= IN_RESET;
      end
      acc_a_reg <= ACC_RESET;
      acc_b_reg <= ACC_RESET;
    end else begin
      in_reg <= in_next;
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x_rd_data_reg <= IN_RESET;
      g_rd_data_reg <= IN_RESET;
      x_rd_valid_reg <= 1'b0;
      g_rd_valid_reg <= 1'b0;
    end else begin
      x_rd_valid_reg <= x_rd_en;
      g_rd_valid_reg <= g_rd_en;
      if (x_rd_en) begin
        x_rd_data_reg <= x_rd_word;
      end
      if (g_rd_en) begin
        g_rd_data_reg <= g_rd_word;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_zero_reg <= 1'b0;
      flag_neg_reg <= 1'b0;
      flag_ext_reg <= 1'b0;
      flag_ovf_reg <= 1'b0;
      flag_limit_reg <= 1'b0;
    end else begin
      flag_limit_reg <= limit_next;
      if (op_active) begin
        flag_zero_reg <= res_zero;
        flag_neg_reg <= alu_res[39];
        flag_ext_reg <= res_ext;
        flag_ovf_reg <= alu_arith & alu_ovf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign x_rd_data = x_rd_data_reg;
  assign g_rd_data = g_rd_data_reg;
  assign x_rd_valid = x_rd_valid_reg;
  assign g_rd_valid = g_rd_valid_reg;
  assign flag_zero = flag_zero_reg;
  assign flag_neg = flag_neg_reg;
  assign flag_ext = flag_ext_reg;
  assign flag_ovf = flag_ovf_reg;
  assign flag_limit = flag_limit_reg;

endmodule
`default_nettype wire

/* tb/mda_data_alu_chk.sv */
// port-level assertion checker for the data arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module mda_data_alu_chk
  import mda_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controls
  input wire mda_op_type op_code,
  input wire logic limit_flag_clr,
  // buses
  input wire logic x_wr_en,
  input wire mda_reg_sel_type x_wr_sel,
  input wire logic [15:0] x_wr_data,
  input wire logic x_rd_en,
  input wire mda_reg_sel_type x_rd_sel,
  input wire logic [15:0] x_rd_data,
  input wire logic x_rd_valid,
  input wire logic g_rd_en,
  input wire logic g_rd_valid,
  // flags
  input wire logic flag_zero,
  input wire logic flag_neg,
  input wire logic flag_ext,
  input wire logic flag_ovf,
  input wire logic flag_limit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  x_rd_pulse_a: assert property (x_rd_en |=> x_rd_valid)
    else $error("x read not answered");
  x_rd_idle_a: assert property (!x_rd_en |=> !x_rd_valid)
    else $error("x read valid without request");
  g_rd_pulse_a: assert property (g_rd_en |=> g_rd_valid)
    else $error("global read not answered");
  x_rd_hold_a: assert property (!x_rd_en |=> $stable(x_rd_data))
    else $error("x read data moved without read");
  x_wr_back_a: assert property ((x_wr_en && x_wr_sel == RS_X_LOW) ##1
    (x_rd_en && x_rd_sel == RS_X_LOW) |=> x_rd_data == $past(x_wr_data, 2))
    else $error("input register lost its bus write");
  rd_unmapped_a: assert property (x_rd_en && x_rd_sel > RS_B_WHOLE |=>
    x_rd_data == 16'h0000) else $error("unmapped read not zero");
  limit_sticky_a: assert property (flag_limit && !limit_flag_clr |=> flag_limit)
    else $error("limit flag dropped");
  limit_clear_a: assert property (limit_flag_clr && !x_rd_en && !g_rd_en |=>
    !flag_limit) else $error("limit flag not cleared");
  limit_value_a: assert property ((x_rd_en && x_rd_sel == RS_A_WHOLE && !g_rd_en &&
    !flag_limit) ##1 flag_limit |-> x_rd_data inside {SAT_POS, SAT_NEG})
    else $error("limited read not clamped");
  flags_hold_a: assert property (op_code == OP_NOP |=>
    $stable({flag_zero, flag_neg, flag_ext, flag_ovf})) else $error("flags moved on idle");
  logic_novf_a: assert property (op_code inside {OP_AND, OP_OR, OP_XOR, OP_NOT} |=>
    !flag_ovf) else $error("logic op set overflow");
endmodule
`default_nettype wire

/* tb/mda_xmem_model.sv */
// x data memory side model moving words into the unit over both buses
`timescale 1ns/1ps
`default_nettype none
module mda_xmem_model
  import mda_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // transfer requests
  input wire logic req_x,
  input wire logic req_g,
  input wire mda_reg_sel_type sel_x,
  input wire mda_reg_sel_type sel_g,
  // unit write side
  output var logic x_wr_en,
  output var mda_reg_sel_type x_wr_sel,
  output var logic [15:0] x_wr_data,
  output var logic g_wr_en,
  output var mda_reg_sel_type g_wr_sel,
  output var logic [15:0] g_wr_data
);
  logic [15:0] mem [0:1];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x_wr_en <= 1'b0;
      g_wr_en <= 1'b0;
      x_wr_sel <= RS_X_LOW;
      g_wr_sel <= RS_X_LOW;
      x_wr_data <= 16'h0000;
      g_wr_data <= 16'h0000;
    end else begin
      x_wr_en <= #1 req_x;
      g_wr_en <= #1 req_g;
      x_wr_sel <= #1 sel_x;
      g_wr_sel <= #1 sel_g;
      // released lines show the inverse of the last word
      x_wr_data <= #1 req_x ? mem[0] : ~x_wr_data;
      g_wr_data <= #1 req_g ? mem[1] : ~g_wr_data;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking testbench of the data arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mda_pkg::*;
  logic clk, reset_n, op_dst_b, int_mode, round_convergent, limit_flag_clr, req_x, req_g;
  logic x_wr_en, g_wr_en, x_rd_en, g_rd_en, x_rd_valid, g_rd_valid;
  logic flag_zero, flag_neg, flag_ext, flag_ovf, flag_limit;
  logic [15:0] x_wr_data, g_wr_data, x_rd_data, g_rd_data;
  mda_op_type op_code;
  mda_src_type op_src;
  mda_mul_sel_type mul_sel_a, mul_sel_b;
  mda_sign_type sign_mode;
  mda_reg_sel_type x_wr_sel, g_wr_sel, x_rd_sel, g_rd_sel, sel_x, sel_g;
  int n_fail, cmp_count;

  mda_data_alu i_mda_data_alu (.clk, .reset_n, .op_code, .op_dst_b, .op_src, .mul_sel_a,
    .mul_sel_b, .sign_mode, .int_mode, .round_convergent, .x_wr_en, .x_wr_sel, .x_wr_data,
    .x_rd_en, .x_rd_sel, .x_rd_data, .x_rd_valid, .g_wr_en, .g_wr_sel, .g_wr_data, .g_rd_en,
    .g_rd_sel, .g_rd_data, .g_rd_valid, .limit_flag_clr, .flag_zero, .flag_neg, .flag_ext,
    .flag_ovf, .flag_limit);
  mda_xmem_model i_mda_xmem_model (.clk, .reset_n, .req_x, .req_g, .sel_x, .sel_g,
    .x_wr_en, .x_wr_sel, .x_wr_data, .g_wr_en, .g_wr_sel, .g_wr_data);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    cmp_count++;
    if (v !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic ld2(input mda_reg_sel_type sx, input logic [15:0] vx, input logic rx,
                     input mda_reg_sel_type sg, input logic [15:0] vg, input logic rg);
    step;
    i_mda_xmem_model.mem[0] = vx;
    i_mda_xmem_model.mem[1] = vg;
    sel_x = sx;
    sel_g = sg;
    req_x = rx;
    req_g = rg;
    step;
    req_x = 1'b0;
    req_g = 1'b0;
  endtask
  task automatic ld(input mda_reg_sel_type s, input logic [15:0] v, input logic on_g);
    ld2(s, v, !on_g, s, v, on_g);
  endtask
  task automatic rd(input mda_reg_sel_type s, input logic [15:0] e, input logic on_g);
    step;
    x_rd_sel = s;
    g_rd_sel = s;
    x_rd_en = !on_g;
    g_rd_en = on_g;
    step;
    x_rd_en = 1'b0;
    g_rd_en = 1'b0;
    chk("read valid", 16'h0001, {15'h0000, on_g ? g_rd_valid : x_rd_valid});
    chk(s.name(), e, on_g ? g_rd_data : x_rd_data);
  endtask
  task automatic op(input mda_op_type c, input logic d);
    step;
    op_code = c;
    op_dst_b = d;
    step;
    op_code = OP_NOP;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    ld(RS_X_LOW, 16'h1111, 0);
    rd(RS_X_LOW, 16'h1111, 0);
    ld(RS_X_HIGH, 16'h2222, 1);
    rd(RS_X_HIGH, 16'h2222, 1);
    ld2(RS_Y_LOW, 16'h3333, 1, RS_Y_HIGH, 16'h4444, 1);
    rd(RS_Y_LOW, 16'h3333, 1);
    rd(RS_Y_HIGH, 16'h4444, 0);
    rd(mda_reg_sel_type'(4'hc), 16'h0000, 0);
    ld(RS_A_LOWER, 16'h5555, 0);
    ld(RS_A_WHOLE, 16'h8001, 1);
    rd(RS_A_EXT, 16'hffff, 0);
    rd(RS_A_LOWER, 16'h0000, 1);
    rd(RS_A_UPPER, 16'h8001, 0);
    $display("test registers done");
  endtask
  task automatic t_mac;
    ld2(RS_X_LOW, 16'h4000, 1, RS_Y_LOW, 16'h2000, 1);
    mul_sel_a = MS_X_LOW;
    mul_sel_b = MS_Y_LOW;
    step;
    op_code = OP_MPY;
    step;
    op_code = OP_MAC;
    step;
    op_code = OP_NOP;
    rd(RS_A_UPPER, 16'h2000, 0);
    op(OP_MACN, 0);
    rd(RS_A_UPPER, 16'h1000, 1);
    mul_sel_a = MS_A_UPPER;
    op(OP_MPYN, 1);
    rd(RS_B_EXT, 16'hffff, 0);
    rd(RS_B_UPPER, 16'hfc00, 1);
    chk("flags", 16'h0004, {12'h000, flag_zero, flag_neg, flag_ext, flag_ovf});
    $display("test multiply accumulate done");
  endtask
  task automatic t_int;
    ld2(RS_X_HIGH, 16'h0003, 1, RS_Y_HIGH, 16'hfffe, 1);
    mul_sel_a = MS_X_HIGH;
    mul_sel_b = MS_Y_HIGH;
    op(OP_INT_MPY, 0);
    rd(RS_A_LOWER, 16'hfffa, 0);
    op(OP_INT_MAC, 0);
    rd(RS_A_LOWER, 16'hfff4, 1);
    rd(RS_A_UPPER, 16'hffff, 0);
    ld2(RS_X_LOW, 16'hffff, 1, RS_Y_LOW, 16'hffff, 1);
    mul_sel_a = MS_X_LOW;
    mul_sel_b = MS_Y_LOW;
    sign_mode = SGN_UU;
    op(OP_MPY, 1);
    rd(RS_B_EXT, 16'h0001, 0);
    rd(RS_B_UPPER, 16'hfffc, 1);
    rd(RS_B_LOWER, 16'h0002, 0);
    sign_mode = SGN_SU;
    op(OP_MPY, 1);
    rd(RS_B_UPPER, 16'hfffe, 1);
    sign_mode = SGN_SS;
    ld(RS_A_WHOLE, 16'h0001, 0);
    ld(RS_A_LOWER, 16'h1234, 1);
    int_mode = 1'b1;
    op_src = SRC_X_HIGH;
    op(OP_ADD, 0);
    rd(RS_A_UPPER, 16'h0004, 0);
    op(OP_SUB, 0);
    op(OP_SUB, 0);
    rd(RS_A_EXT, 16'hffff, 1);
    rd(RS_A_LOWER, 16'h1234, 0);
    int_mode = 1'b0;
    $display("test integer and sign modes done");
  endtask
  task automatic t_arith;
    ld2(RS_A_WHOLE, 16'h4000, 1, RS_B_WHOLE, 16'h4000, 1);
    op_src = SRC_OTHER_ACC;
    op(OP_ADD, 0);
    rd(RS_A_EXT, 16'h0000, 1);
    rd(RS_A_UPPER, 16'h8000, 0);
    rd(RS_A_WHOLE, 16'h7fff, 0);
    chk("flags", 16'h0002, {12'h000, flag_zero, flag_neg, flag_ext, flag_ovf});
    chk("limit flag", 16'h0001, {15'h0000, flag_limit});
    step;
    limit_flag_clr = 1'b1;
    step;
    limit_flag_clr = 1'b0;
    chk("limit flag", 16'h0000, {15'h0000, flag_limit});
    ld(RS_B_WHOLE, 16'h8000, 1);
    op(OP_ASL, 1);
    rd(RS_B_WHOLE, 16'h8000, 1);
    op(OP_ASR, 1);
    rd(RS_B_UPPER, 16'h8000, 0);
    op(OP_SUB, 0);
    rd(RS_A_EXT, 16'h0001, 1);
    $display("test add, shift and limit done");
  endtask
  task automatic t_logic;
    mda_op_type lops [4] = '{OP_AND, OP_OR, OP_XOR, OP_NOT};
    logic [15:0] lexp [4] = '{16'hf000, 16'hff00, 16'h0000, 16'hffff};
    ld(RS_A_WHOLE, 16'hf0f0, 0);
    ld(RS_A_LOWER, 16'h5a5a, 1);
    ld(RS_A_EXT, 16'h3312, 0);
    ld(RS_X_LOW, 16'hff00, 1);
    op_src = SRC_X_LOW;
    for (int i = 0; i < 4; i++) begin
      op(lops[i], 0);
      rd(RS_A_UPPER, lexp[i], i[0]);
    end
    rd(RS_A_LOWER, 16'h5a5a, 0);
    rd(RS_A_EXT, 16'h0012, 1);
    $display("test logic done");
  endtask
  task automatic t_round;
    for (int i = 0; i < 2; i++) begin
      ld(RS_A_WHOLE, 16'h0002, 0);
      ld(RS_A_LOWER, 16'h8000, 1);
      round_convergent = ~i[0];
      op(OP_RND, 0);
      rd(RS_A_UPPER, i[0] ? 16'h0003 : 16'h0002, 0);
    end
    $display("test rounding done");
  endtask

  initial begin
    reset_n = 1'b0;
    {op_dst_b, int_mode, round_convergent, limit_flag_clr} = 4'h0;
    {req_x, req_g, x_rd_en, g_rd_en} = 4'h0;
    op_code = OP_NOP;
    op_src = SRC_X_LOW;
    mul_sel_a = MS_X_LOW;
    mul_sel_b = MS_Y_LOW;
    sign_mode = SGN_SS;
    {x_rd_sel, g_rd_sel, sel_x, sel_g} = {4{RS_X_LOW}};
    n_fail = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    t_regs;
    t_mac;
    t_int;
    t_arith;
    t_logic;
    t_round;
    stop_test;
  end

  initial begin
    #20000;
    n_fail++;
    $display("watchdog expired");
    stop_test;
  end
endmodule

bind mda_data_alu mda_data_alu_chk i_mda_data_alu_chk (.clk, .reset_n, .op_code,
  .limit_flag_clr, .x_wr_en, .x_wr_sel, .x_wr_data, .x_rd_en, .x_rd_sel, .x_rd_data,
  .x_rd_valid, .g_rd_en, .g_rd_valid, .flag_zero, .flag_neg, .flag_ext, .flag_ovf,
  .flag_limit);
`default_nettype wire
